// ===== pkg/lcdgc_pkg.sv
// lcdgc_pkg: constants for the general-control command decoder
// assumes a 250 MHz mclk and three-byte command frames
package lcdgc_pkg;
  localparam int unsigned MCLK_MHZ    = 250;
  localparam int unsigned CAL_TIME_US = 10000;
  localparam int unsigned CAL_CYCLES  = CAL_TIME_US * MCLK_MHZ;
  localparam int unsigned CAL_CNT_W   = 22;
  localparam int unsigned FRAME_BITS  = 24;
  localparam logic [4:0]  FRAME_LAST  = 5'h17;
  // byte 1: i2c keeps r/w in bit 0, spi in bit 7
  localparam int unsigned RW_POS_I2C  = 16;
  localparam int unsigned RW_POS_SPI  = 23;
  // byte 2: continuation bit 7, register group select bits 6:5
  localparam int unsigned CONT_POS    = 15;
  localparam int unsigned RGS_HI      = 14;
  localparam int unsigned RGS_LO      = 13;
  localparam logic [1:0]  RGS_GENERAL = 2'h0;
  localparam logic [1:0]  RGS_RAM     = 2'h1;
  localparam logic [1:0]  RGS_DISPLAY = 2'h2;
  localparam logic [1:0]  RGS_PUMP    = 2'h3;
  // general control codes
  localparam logic [7:0]  CMD_INIT      = 8'h01;
  localparam logic [7:0]  CMD_CLR_FLAG  = 8'h1F;
  localparam logic [7:0]  CMD_CAL_RELOAD = 8'h02;
  localparam logic [6:0]  CMD_CLKOUT_HI = 7'h10;
  localparam logic [5:0]  CMD_RDSEL_HI  = 6'h01;
  localparam int unsigned COE_POS       = 0;
  localparam int unsigned XC_POS        = 1;
  localparam int unsigned SO_POS        = 0;
  // reset values
  localparam logic        COE_RST   = 1'b0;
  localparam logic        XC_RST    = 1'b0;
  localparam logic        SO_RST    = 1'b0;
  localparam logic        RFLAG_RST = 1'b1;
  // internal oscillator: mclk divided by 2*(OSC_HALF+1)
  localparam logic [3:0]  OSC_HALF  = 4'h7;
  typedef enum logic [1:0] {
    LCDGC_IDLE = 2'b00,
    LCDGC_CAL  = 2'b01,
    LCDGC_PEND = 2'b10
  } lcdgc_state_t;
endpackage

// ===== hw/lcdgc_sync.sv
// lcdgc_sync: two-flop synchroniser for one level
// assumes d is a level from another domain or a pin
`timescale 1ns/1ns
`default_nettype none
module lcdgc_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== hw/lcdgc_link_rx.sv
// lcdgc_link_rx: gathers 24 frame bits on the link clock
// assumes link_clk runs only inside frames, msb first, link_sel_n high between frames
`timescale 1ns/1ns
`default_nettype none
module lcdgc_link_rx
  import lcdgc_pkg::*;
(
  input  wire logic        link_clk,
  input  wire logic        rst_n,
  input  wire logic        link_sel_n,
  input  wire logic        link_sdi,
  output logic [23:0]      frame_q,
  output logic             frame_tog_q
);
  logic [4:0]  bit_cnt_q;
  logic [22:0] shift_q;

  // the frame's own select ends the count, no link edge needed after it
  always_ff @(posedge link_clk or posedge link_sel_n) begin
    if (link_sel_n) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q == FRAME_LAST) begin
      bit_cnt_q <= 5'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge link_clk) begin
    shift_q <= {shift_q[21:0], link_sdi};
  end

  // frame word stays put for a whole frame, long enough to cross
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q     <= 24'h000000;
      frame_tog_q <= 1'b0;
    end else if (!link_sel_n && bit_cnt_q == FRAME_LAST) begin
      frame_q     <= {shift_q, link_sdi};
      frame_tog_q <= ~frame_tog_q;
    end
  end
endmodule
`default_nettype wire

// ===== hw/lcdgc_cmd_decoder.sv
// lcdgc_cmd_decoder: general-control command decoder of the lcd driver
// assumes frames arrive on link_clk, enables come from mclk-domain blocks
//
// What this block does
// - Each command frame is three bytes: address/rw, select byte, command.
// - Decode uses the two-bit group select plus read/write direction.
// - Initialize write returns every command register to its default.
// - Clear-flag code clears the reset-occurred flag.
// - Initialize or reload copies factory calibration into its registers.
// - Code 0x02 is the calibration reload command.
// - Reload takes about 10 ms; the last command sent meanwhile runs when it ends.
// - Clock-out command bit 0 enables driving the clock pin.
// - Enable 0 leaves clock pin floating; enable 1 drives it while the oscillator pin is low.
// - Internal clock runs only while display, pump or sensor enabled.
// - Readout command: bit 1 picks checksum kind, bit 0 readout.
// - Reset-occurred flag is set by every reset, starts at one.
// - Oscillator pin low outputs internal clock; high accepts external clock.
// - Clock-out enable reads back in bit 0 of status byte nine.
`timescale 1ns/1ns
`default_nettype none
module lcdgc_cmd_decoder
  import lcdgc_pkg::*;
#(
  parameter int unsigned CAL_WAIT = CAL_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        link_clk,
  input  wire logic        link_sel_n,
  input  wire logic        link_sdi,
  input  wire logic        iface_spi,
  input  wire logic        oscillator_source_pin,
  input  wire logic        clk_pin_i,
  output logic             clk_pin_o,
  output logic             clk_pin_oe,
  input  wire logic        display_enable,
  input  wire logic        charge_pump_enable,
  input  wire logic        temp_meas_enable,
  input  wire logic        pump_ready,
  input  wire logic [8:0]  otp_vlcd,
  input  wire logic [4:0]  otp_frame,
  input  wire logic [7:0]  otp_temp,
  output logic [8:0]       cal_vlcd_q,
  output logic [4:0]       cal_frame_q,
  output logic [7:0]       cal_temp_q,
  output logic             chip_init_q,
  output logic             cal_busy_q,
  output logic             clock_pin_drive_enable_q,
  output logic             checksum_algorithm_select_q,
  output logic             readout_status_select_q,
  output logic             reset_occurred_flag_q,
  output logic [7:0]       status_reg9_q,
  output logic             core_clk_q
);

  ////////////////////////////////////////////////////////////////////////////
  // link crossing
  logic [23:0] frame_q;
  logic        frame_tog_q;
  logic        tog_s, tog_seen_q, osc_sel_s, ext_clk_s, spi_s;

  lcdgc_link_rx u_rx (
    .link_clk    (link_clk),
    .rst_n       (rst_n),
    .link_sel_n  (link_sel_n),
    .link_sdi    (link_sdi),
    .frame_q     (frame_q),
    .frame_tog_q (frame_tog_q)
  );

  lcdgc_sync u_sync_tog (.mclk(mclk), .rst_n(rst_n), .d(frame_tog_q), .q(tog_s));
  lcdgc_sync u_sync_osc (.mclk(mclk), .rst_n(rst_n), .d(oscillator_source_pin),
                         .q(osc_sel_s));
  lcdgc_sync u_sync_ext (.mclk(mclk), .rst_n(rst_n), .d(clk_pin_i), .q(ext_clk_s));
  lcdgc_sync u_sync_spi (.mclk(mclk), .rst_n(rst_n), .d(iface_spi), .q(spi_s));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tog_seen_q <= 1'b0;
    end else begin
      tog_seen_q <= tog_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame fields
  logic       frame_new, rw_bit, is_write_gen;
  logic [1:0] grp_sel;
  logic [7:0] cmd_byte;

  // the frame word is stable here: it changed before the toggle crossed
  assign frame_new    = tog_s ^ tog_seen_q;
  assign rw_bit       = spi_s ? frame_q[RW_POS_SPI] : frame_q[RW_POS_I2C];
  assign grp_sel      = frame_q[RGS_HI:RGS_LO];
  assign cmd_byte     = frame_q[7:0];
  assign is_write_gen = frame_new && !rw_bit && (grp_sel == RGS_GENERAL);

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  logic do_init, do_clr, do_reload, do_clkout, do_rdsel, cmd_valid;

  // any other general code falls through and touches nothing
  always_comb begin
    do_init   = 1'b0;
    do_clr    = 1'b0;
    do_reload = 1'b0;
    do_clkout = 1'b0;
    do_rdsel  = 1'b0;
    if (is_write_gen) begin
      do_init   = (cmd_byte == CMD_INIT);
      do_clr    = (cmd_byte == CMD_CLR_FLAG);
      do_reload = (cmd_byte == CMD_CAL_RELOAD);
      do_clkout = (cmd_byte[7:1] == CMD_CLKOUT_HI);
      do_rdsel  = (cmd_byte[7:2] == CMD_RDSEL_HI);
    end
  end

  assign cmd_valid = do_init | do_clr | do_reload | do_clkout | do_rdsel;

  ////////////////////////////////////////////////////////////////////////////
  // busy sequencing
  lcdgc_state_t         state_q;
  logic [CAL_CNT_W-1:0] cal_cnt_q;
  logic [7:0]           pend_cmd_q;
  logic [7:0]           exec_byte;
  logic                 cal_done, pend_go;
  logic                 exec_init, exec_clr, exec_reload, exec_clkout, exec_rdsel;

  localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_WAIT - 1);

  assign cal_done = (state_q != LCDGC_IDLE) && (cal_cnt_q == CAL_LAST);
  // a frame received while busy waits here and runs when the reload ends
  assign pend_go  = cal_done && (state_q == LCDGC_PEND);

  always_comb begin
    exec_byte   = cmd_byte;
    exec_init   = 1'b0;
    exec_clr    = 1'b0;
    exec_reload = 1'b0;
    exec_clkout = 1'b0;
    exec_rdsel  = 1'b0;
    if (pend_go) begin
      exec_byte   = pend_cmd_q;
      exec_init   = (pend_cmd_q == CMD_INIT);
      exec_clr    = (pend_cmd_q == CMD_CLR_FLAG);
      exec_reload = (pend_cmd_q == CMD_CAL_RELOAD);
      exec_clkout = (pend_cmd_q[7:1] == CMD_CLKOUT_HI);
      exec_rdsel  = (pend_cmd_q[7:2] == CMD_RDSEL_HI);
    end else if (state_q == LCDGC_IDLE) begin
      exec_init   = do_init;
      exec_clr    = do_clr;
      exec_reload = do_reload;
      exec_clkout = do_clkout;
      exec_rdsel  = do_rdsel;
    end
  end

  // one pending slot only: a second frame during busy replaces the first
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q    <= LCDGC_IDLE;
      pend_cmd_q <= 8'h00;
    end else begin
      unique case (state_q)
        LCDGC_IDLE: begin
          if (exec_init || exec_reload) begin
            state_q <= LCDGC_CAL;
          end
        end
        LCDGC_CAL: begin
          if (cmd_valid) begin
            state_q    <= LCDGC_PEND;
            pend_cmd_q <= cmd_byte;
          end else if (cal_done) begin
            state_q <= LCDGC_IDLE;
          end
        end
        LCDGC_PEND: begin
          if (cmd_valid) begin
            pend_cmd_q <= cmd_byte;
          end else if (cal_done) begin
            state_q <= (exec_init || exec_reload) ? LCDGC_CAL : LCDGC_IDLE;
          end
        end
        default: begin
          state_q <= LCDGC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cal_cnt_q <= '0;
    end else if (state_q == LCDGC_IDLE || cal_done) begin
      cal_cnt_q <= '0;
    end else begin
      cal_cnt_q <= cal_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cal_busy_q <= 1'b0;
    end else begin
      cal_busy_q <= (state_q != LCDGC_IDLE && !(cal_done && !pend_go))
                    || exec_init || exec_reload;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clock_pin_drive_enable_q <= COE_RST;
    end else if (exec_init) begin
      clock_pin_drive_enable_q <= COE_RST;
    end else if (exec_clkout) begin
      clock_pin_drive_enable_q <= exec_byte[COE_POS];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      checksum_algorithm_select_q <= XC_RST;
      readout_status_select_q     <= SO_RST;
    end else if (exec_init) begin
      checksum_algorithm_select_q <= XC_RST;
      readout_status_select_q     <= SO_RST;
    end else if (exec_rdsel) begin
      checksum_algorithm_select_q <= exec_byte[XC_POS];
      readout_status_select_q     <= exec_byte[SO_POS];
    end
  end

  // initialize is itself a reset, so it sets the flag as well
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reset_occurred_flag_q <= RFLAG_RST;
    end else if (exec_init) begin
      reset_occurred_flag_q <= 1'b1;
    end else if (exec_clr) begin
      reset_occurred_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chip_init_q <= 1'b0;
    end else begin
      chip_init_q <= exec_init;
    end
  end

  // calibration lands when the reload time is over
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cal_vlcd_q  <= 9'h000;
      cal_frame_q <= 5'h00;
      cal_temp_q  <= 8'h00;
    end else if (cal_done) begin
      cal_vlcd_q  <= otp_vlcd;
      cal_frame_q <= otp_frame;
      cal_temp_q  <= otp_temp;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_reg9_q <= 8'h00;
    end else begin
      status_reg9_q <= {5'h00, pump_ready, reset_occurred_flag_q,
                        clock_pin_drive_enable_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clocking and the clock pin
  logic       clk_run_q, osc_q;
  logic [3:0] osc_div_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clk_run_q <= 1'b0;
    end else begin
      clk_run_q <= display_enable | charge_pump_enable | temp_meas_enable;
    end
  end

  // stopped oscillator saves power; divider parks low
  always_ff @(posedge mclk) begin
    if (!rst_n || !clk_run_q) begin
      osc_div_q <= 4'h0;
      osc_q     <= 1'b0;
    end else if (osc_div_q == OSC_HALF) begin
      osc_div_q <= 4'h0;
      osc_q     <= ~osc_q;
    end else begin
      osc_div_q <= osc_div_q + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      core_clk_q <= 1'b0;
      clk_pin_o  <= 1'b0;
      clk_pin_oe <= 1'b0;
    end else begin
      core_clk_q <= osc_sel_s ? (ext_clk_s & clk_run_q) : osc_q;
      clk_pin_o  <= osc_q;
      clk_pin_oe <= !osc_sel_s && clock_pin_drive_enable_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_INIT_DEFAULTS: assert property (@(posedge mclk) disable iff (!rst_n)
    exec_init |=> !clock_pin_drive_enable_q && !checksum_algorithm_select_q
                  && !readout_status_select_q && reset_occurred_flag_q)
    else $error("initialize left a register off its default");

  AST_CLR_FLAG: assert property (@(posedge mclk) disable iff (!rst_n)
    exec_clr |=> !reset_occurred_flag_q)
    else $error("clear command did not clear the reset flag");

  AST_RELOAD_BUSY: assert property (@(posedge mclk) disable iff (!rst_n)
    (exec_reload || exec_init) |=> cal_busy_q [*8])
    else $error("reload did not raise busy");

  AST_CAL_LOAD: assert property (@(posedge mclk) disable iff (!rst_n)
    cal_done |=> cal_vlcd_q == $past(otp_vlcd) && cal_temp_q == $past(otp_temp))
    else $error("calibration values not loaded at reload end");

  AST_CAL_LEN: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q != LCDGC_IDLE && cal_cnt_q != CAL_LAST)
      |=> state_q != LCDGC_IDLE && cal_cnt_q == $past(cal_cnt_q) + 1'b1)
    else $error("reload ended before its full count");

  AST_PIN_FLOAT: assert property (@(posedge mclk) disable iff (!rst_n)
    !clock_pin_drive_enable_q |=> !clk_pin_oe)
    else $error("clock pin driven while output disabled");

  AST_RDSEL: assert property (@(posedge mclk) disable iff (!rst_n)
    (exec_rdsel && !exec_init) |=> checksum_algorithm_select_q == $past(exec_byte[XC_POS])
                     && readout_status_select_q == $past(exec_byte[SO_POS]))
    else $error("readout select not taken");

  AST_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    !clk_run_q |=> !osc_q)
    else $error("oscillator ran with all users off");

  AST_STATUS9: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> status_reg9_q[COE_POS] == $past(clock_pin_drive_enable_q))
    else $error("status bit 0 does not follow clock-out enable");

  AST_IGNORE: assert property (@(posedge mclk) disable iff (!rst_n)
    (frame_new && !cmd_valid && !pend_go) |=> $stable(clock_pin_drive_enable_q)
      && $stable(readout_status_select_q) && $stable(reset_occurred_flag_q))
    else $error("undefined frame changed a register");

  AST_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == LCDGC_CAL && do_clkout && !cal_done) |=> $stable(clock_pin_drive_enable_q))
    else $error("command ran during calibration");
endmodule
`default_nettype wire

// ===== testbench/lcdgc_host_model.sv
// lcdgc_host_model: host side of the serial command link
// assumes send_frame is called between mclk edges; link clock idles low
`timescale 1ns/1ns
`default_nettype none
module lcdgc_host_model (
  output logic link_clk,
  output logic link_sel_n,
  output logic link_sdi
);
  initial begin
    link_clk   = 1'b0;
    link_sel_n = 1'b1;
    link_sdi   = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // three whole bytes, msb first, 30 ns bit clock only inside the frame
  task automatic send_frame(input logic [23:0] frame);
    link_sel_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      link_sdi = frame[i];
      #15 link_clk = 1'b1;
      #15 link_clk = 1'b0;
    end
    #15 link_sel_n = 1'b1;
    // released line must not look like a held bit
    link_sdi = ~link_sdi;
  endtask
endmodule
`default_nettype wire

// ===== testbench/lcdgc_cmd_decoder_bench.sv
// lcdgc_cmd_decoder_bench: self-checking bench of the command decoder
// assumes lcdgc_pkg is compiled first; reload shortened to CW mclk cycles
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module lcdgc_cmd_decoder_bench;
  import lcdgc_pkg::*;
  // long enough to hold a second frame inside the reload
  localparam int unsigned CW = 400;
  logic mclk = 1'b0, rst_n = 1'b0, iface_spi = 1'b0, oscillator_source_pin = 1'b0;
  logic clk_pin_i = 1'b0, display_enable = 1'b0, charge_pump_enable = 1'b0;
  logic temp_meas_enable = 1'b0, pump_ready = 1'b0;
  logic [8:0] otp_vlcd = 9'h000;
  logic [4:0] otp_frame = 5'h00;
  logic [7:0] otp_temp = 8'h00;
  logic link_clk, link_sel_n, link_sdi, clk_pin_o, clk_pin_oe, chip_init_q, cal_busy_q;
  logic clock_pin_drive_enable_q, checksum_algorithm_select_q, readout_status_select_q;
  logic reset_occurred_flag_q, core_clk_q;
  logic [8:0] cal_vlcd_q;
  logic [4:0] cal_frame_q;
  logic [7:0] cal_temp_q, status_reg9_q;
  logic exp_coe = 1'b0, exp_xc = 1'b0, exp_so = 1'b0, exp_flag = 1'b1;
  int   n_mismatch = 0, compares = 0, n_init = 0, busy_cyc = 0;

  lcdgc_host_model u_lcdgc_host_model (
    .link_clk   (link_clk),
    .link_sel_n (link_sel_n),
    .link_sdi   (link_sdi)
  );
  lcdgc_cmd_decoder #(.CAL_WAIT(CW)) u_lcdgc_cmd_decoder (
    .mclk(mclk), .rst_n(rst_n), .link_clk(link_clk), .link_sel_n(link_sel_n),
    .link_sdi(link_sdi), .iface_spi(iface_spi),
    .oscillator_source_pin(oscillator_source_pin), .clk_pin_i(clk_pin_i),
    .clk_pin_o(clk_pin_o), .clk_pin_oe(clk_pin_oe), .display_enable(display_enable),
    .charge_pump_enable(charge_pump_enable), .temp_meas_enable(temp_meas_enable),
    .pump_ready(pump_ready), .otp_vlcd(otp_vlcd), .otp_frame(otp_frame),
    .otp_temp(otp_temp), .cal_vlcd_q(cal_vlcd_q), .cal_frame_q(cal_frame_q),
    .cal_temp_q(cal_temp_q), .chip_init_q(chip_init_q), .cal_busy_q(cal_busy_q),
    .clock_pin_drive_enable_q(clock_pin_drive_enable_q),
    .checksum_algorithm_select_q(checksum_algorithm_select_q),
    .readout_status_select_q(readout_status_select_q),
    .reset_occurred_flag_q(reset_occurred_flag_q), .status_reg9_q(status_reg9_q),
    .core_clk_q(core_clk_q)
  );

  always #2 mclk = ~mclk;
  always #20 clk_pin_i = ~clk_pin_i;
  always @(posedge mclk) begin
    if (chip_init_q === 1'b1) n_init++;
    if (cal_busy_q === 1'b1) busy_cyc++;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_regs();
    `CHECK(clock_pin_drive_enable_q, exp_coe);
    `CHECK(checksum_algorithm_select_q, exp_xc);
    `CHECK(readout_status_select_q, exp_so);
    `CHECK(reset_occurred_flag_q, exp_flag);
    `CHECK(status_reg9_q, {5'h00, pump_ready, exp_flag, exp_coe});
  endtask

  // unimplemented bits and continuation bit go out as zero
  task automatic cmd(input logic rw, input logic [1:0] grp, input logic [7:0] code);
    logic [7:0] b1;
    b1 = iface_spi ? {rw, 7'h00} : {7'h00, rw};
    @(negedge mclk);
    #1 u_lcdgc_host_model.send_frame({b1, 1'b0, grp, 5'h00, code});
    repeat (8) @(negedge mclk);
    chk_regs();
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (cal_busy_q === 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    `CHECK(cal_busy_q, 1'b0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_cal(input logic [7:0] code, input logic [8:0] v,
                          input logic [4:0] f, input logic [7:0] t);
    int n0;
    n0 = n_init;
    otp_vlcd = v;
    otp_frame = f;
    otp_temp = t;
    if (code == CMD_INIT) begin
      exp_coe = 1'b0;
      exp_xc = 1'b0;
      exp_so = 1'b0;
      exp_flag = 1'b1;
    end
    busy_cyc = 0;
    cmd(1'b0, RGS_GENERAL, code);
    `CHECK(n_init, n0 + int'(code == CMD_INIT));
    `CHECK(cal_busy_q, 1'b1);
    cmd(1'b0, RGS_GENERAL, {CMD_CLKOUT_HI, ~exp_coe});
    wait_idle();
    exp_coe = ~exp_coe;
    `CHECK(busy_cyc >= CW && busy_cyc <= CW + 2, 1'b1);
    repeat (6) @(negedge mclk);
    chk_regs();
    `CHECK({cal_vlcd_q, cal_frame_q, cal_temp_q}, {v, f, t});
  endtask

  task automatic test_clkout();
    exp_coe = 1'b0;
    cmd(1'b0, RGS_GENERAL, {CMD_CLKOUT_HI, 1'b0});
    `CHECK(clk_pin_oe, 1'b0);
    exp_coe = 1'b1;
    cmd(1'b0, RGS_GENERAL, {CMD_CLKOUT_HI, 1'b1});
    `CHECK(clk_pin_oe, 1'b1);
    oscillator_source_pin = 1'b1;
    repeat (6) @(negedge mclk);
    `CHECK(clk_pin_oe, 1'b0);
    oscillator_source_pin = 1'b0;
    repeat (6) @(negedge mclk);
  endtask

  task automatic test_readout();
    for (int i = 0; i < 4; i++) begin
      {exp_xc, exp_so} = i[1:0] + 2'h2;
      cmd(1'b0, RGS_GENERAL, {CMD_RDSEL_HI, i[1:0] + 2'h2});
    end
  endtask

  // every frame here but the last must leave all registers alone; the last, an spi write, flips clock-out enable
  task automatic test_refuse();
    pump_ready = 1'b1;
    cmd(1'b1, RGS_GENERAL, {CMD_CLKOUT_HI, ~exp_coe});
    for (int g = 1; g < 4; g++)
      cmd(1'b0, g[1:0], {CMD_CLKOUT_HI, ~exp_coe});
    cmd(1'b0, RGS_GENERAL, 8'h03);
    cmd(1'b0, RGS_GENERAL, {CMD_CLKOUT_HI, ~exp_coe} | 8'h02);
    iface_spi = 1'b1;
    repeat (4) @(negedge mclk);
    cmd(1'b1, RGS_GENERAL, {CMD_CLKOUT_HI, ~exp_coe});
    exp_coe = ~exp_coe;
    cmd(1'b0, RGS_GENERAL, {CMD_CLKOUT_HI, exp_coe});
    iface_spi = 1'b0;
    repeat (4) @(negedge mclk);
  endtask

  // passes 4 and 5 run on the external clock, with and without a user
  task automatic test_gating();
    int n, m;
    logic last, last_o;
    for (int e = 0; e < 6; e++) begin
      oscillator_source_pin = (e > 3);
      {temp_meas_enable, charge_pump_enable, display_enable} =
        (e == 3 || e == 5) ? 3'h0 : 3'h1 << (e % 4);
      repeat (8) @(negedge mclk);
      n = 0;
      m = 0;
      last = core_clk_q;
      last_o = clk_pin_o;
      for (int c = 0; c < 64; c++) begin
        @(negedge mclk);
        if (core_clk_q !== last) n++;
        if (clk_pin_o !== last_o) m++;
        last = core_clk_q;
        last_o = clk_pin_o;
      end
      `CHECK(n > 0, e != 3 && e != 5);
      `CHECK(clk_pin_oe, exp_coe && e < 4);
      if (e < 4) `CHECK(m > 0, e != 3);
    end
    oscillator_source_pin = 1'b0;
  endtask

  task automatic test_flag();
    exp_flag = 1'b0;
    cmd(1'b0, RGS_GENERAL, CMD_CLR_FLAG);
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    {exp_coe, exp_xc, exp_so, exp_flag} = 4'h1;
    repeat (3) @(negedge mclk);
    chk_regs();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk_regs();
    `CHECK({cal_vlcd_q, cal_frame_q, cal_temp_q, cal_busy_q, clk_pin_oe}, 24'h0);
    test_cal(CMD_INIT, 9'h1A5, 5'h13, 8'h6C);
    test_clkout();
    test_readout();
    test_refuse();
    test_cal(CMD_CAL_RELOAD, 9'h05A, 5'h0C, 8'h93);
    exp_flag = 1'b0;
    cmd(1'b0, RGS_GENERAL, CMD_CLR_FLAG);
    test_cal(CMD_INIT, 9'h0F3, 5'h1E, 8'h21);
    test_gating();
    test_flag();
    finish_test();
  end
endmodule
`default_nettype wire
